/* File: src/lpsc_controller.sv */
// stop-level selection, pin latching, wake decode and clock gating
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module lpsc_controller
  import lpsc_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire lpsc_pkg::lpsc_bus_t  bus,
  output var  logic [7:0]           rdata,
  input  wire logic                 stop_exec,
  input  wire lpsc_pkg::lpsc_wake_t wake_in,
  input  wire logic                 debug_cmd,
  input  wire logic                 debug_status_cmd,
  output var  logic [1:0]           debug_answer,
  output var  lpsc_pkg::lpsc_event_t wake_event,
  output var  logic                 pins_latched,
  output var  logic                 pins_forced_reset,
  output var  logic                 core_clock_enable,
  output var  logic                 periph_clock_enable,
  output var  logic                 debug_clock_enable,
  output var  logic                 oscillator_enable,
  output var  logic                 regulator_full,
  output var  logic                 comparator_enable,
  output var  logic                 periph_reset,
  output var  logic                 memory_retained,
  output var  lpsc_pkg::lpsc_state_t level
);
  import lpsc_pkg::*;

  typedef struct packed {
    lpsc_state_t level;
    logic        power_down_select;
    logic        partial_power_down_select;
    logic        low_voltage_reset_enable;
    logic        stop_enable_bit;
    logic [2:0]  periodic_rate_select;
    logic        debug_mode_enable;
    logic [4:0]  wake_enable;
    logic        recovery_flag;
    logic        latched;
    logic        forced;
    logic        mem_kept;
    logic        resume_reset;
    logic        resume_partial;
    logic [15:0] tick_count;
    logic        tick;
    logic [7:0]  rdata;
    logic [1:0]  dbg_ans;
    lpsc_event_t evt;
    logic        periph_reset;
  } lpsc_ctrl_state_t;

  localparam logic [15:0] TICK_LAST = 16'(PERIODIC_CYCLES - 1);

  lpsc_ctrl_state_t s;
  lpsc_ctrl_state_t next_s;
  logic [17:0] wake_sync;
  logic        rst_pin;
  logic        ext_pin;
  logic [7:0]  key_one;
  logic [7:0]  key_two;
  logic        deep_level;
  logic        ext_hit;
  logic        one_hit;
  logic        two_hit;
  logic        periodic_on;

  ////////////////////////////////////////////////////////////////////////////
  // wake inputs cross in before use
  lpsc_sync #(
    .WIDTH (18)
  ) u_wake_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({wake_in.reset_pin, wake_in.ext_pin,
                wake_in.group_one, wake_in.group_two}),
    .sync_out (wake_sync)
  );

  assign rst_pin = wake_sync[17];
  assign ext_pin = wake_sync[16];
  assign key_one = wake_sync[15:8];
  assign key_two = wake_sync[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // wake decode
  always_comb
  begin
    deep_level  = (s.level == LPSC_DEEPEST) || (s.level == LPSC_PARTIAL);
    periodic_on = (s.periodic_rate_select != RATE_OFF);
    // forced active low in the deep levels
    if (deep_level)
    begin
      ext_hit = s.wake_enable[WE_EXT_PIN] && !ext_pin;
      one_hit = s.wake_enable[WE_GROUP_ONE] && !(&key_one);
    end
    else
    begin
      ext_hit = s.wake_enable[WE_EXT_PIN]
                && (ext_pin == s.wake_enable[WE_EXT_ACTIVE_HIGH]);
      one_hit = s.wake_enable[WE_GROUP_ONE]
                && (s.wake_enable[WE_KEY_ACTIVE_HIGH] ? |key_one
                                                      : !(&key_one));
    end
    two_hit = s.wake_enable[WE_GROUP_TWO]
              && (s.wake_enable[WE_KEY_ACTIVE_HIGH] ? |key_two
                                                    : !(&key_two));
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_s              = s;
    next_s.evt          = '0;
    next_s.tick         = 1'b0;
    next_s.periph_reset = 1'b0;
    next_s.dbg_ans      = '0;
    next_s.rdata        = RESET_BYTE;

    // periodic source
    if (!periodic_on)
      next_s.tick_count = '0;
    else if (s.tick_count == TICK_LAST)
    begin
      next_s.tick_count = '0;
      next_s.tick       = 1'b1;
    end
    else
      next_s.tick_count = s.tick_count + 16'h0001;

    // register writes
    if (bus.write)
    begin
      unique case (bus.addr)
        ADDR_CONTROL_ONE:
          next_s.low_voltage_reset_enable = bus.wdata[C1_LOW_VOLTAGE_RESET];
        ADDR_CONTROL_TWO:
        begin
          next_s.power_down_select = bus.wdata[C2_POWER_DOWN_SELECT];
          next_s.partial_power_down_select = bus.wdata[C2_PARTIAL_SELECT];
          if (bus.wdata[C2_PIN_RELEASE_ACK])
          begin
            next_s.latched       = 1'b0;
            next_s.recovery_flag = 1'b0;
          end
        end
        ADDR_OPTIONS:
        begin
          next_s.stop_enable_bit = bus.wdata[OPT_STOP_ENABLE];
          next_s.periodic_rate_select = bus.wdata[OPT_RATE_LSB +: 3];
        end
        ADDR_DEBUG:
          next_s.debug_mode_enable = bus.wdata[DBG_MODE_ENABLE];
        ADDR_WAKE_ENABLE:
          next_s.wake_enable = bus.wdata[4:0];
        default:
          next_s.wake_enable = s.wake_enable;
      endcase
    end

    // register reads, data in the next cycle
    if (bus.read)
    begin
      unique case (bus.addr)
        ADDR_CONTROL_ONE:
          next_s.rdata[C1_LOW_VOLTAGE_RESET] = s.low_voltage_reset_enable;
        ADDR_CONTROL_TWO:
        begin
          next_s.rdata[C2_POWER_DOWN_SELECT] = s.power_down_select;
          next_s.rdata[C2_PARTIAL_SELECT] = s.partial_power_down_select;
          next_s.rdata[C2_RECOVERY_FLAG]  = s.recovery_flag;
        end
        ADDR_OPTIONS:
        begin
          next_s.rdata[OPT_STOP_ENABLE]  = s.stop_enable_bit;
          next_s.rdata[OPT_RATE_LSB +: 3] = s.periodic_rate_select;
        end
        ADDR_DEBUG:
          next_s.rdata[DBG_MODE_ENABLE] = s.debug_mode_enable;
        ADDR_STATUS:
          next_s.rdata = {3'h0, s.level};
        ADDR_WAKE_ENABLE:
          next_s.rdata = {3'h0, s.wake_enable};
        default:
          next_s.rdata = RESET_BYTE;
      endcase
    end

    // debug status commands
    if (debug_status_cmd)
      next_s.dbg_ans = (s.level == LPSC_RUN || s.level == LPSC_RESUME)
                       ? DBG_ANS_OK : DBG_ANS_STOPPED;

    unique case (s.level)
      LPSC_RUN:
        if (stop_exec)
        begin
          if (!s.stop_enable_bit)
            next_s.evt.illegal_reset = 1'b1;
          else if (!s.power_down_select)
            next_s.level = LPSC_HALTED;
          else if (s.debug_mode_enable || s.low_voltage_reset_enable)
            next_s.level = LPSC_HALTED;
          else if (s.partial_power_down_select)
          begin
            next_s.level   = LPSC_PARTIAL;
            next_s.latched = 1'b1;
          end
          else
          begin
            next_s.level    = LPSC_DEEPEST;
            next_s.forced   = 1'b1;
            next_s.mem_kept = 1'b0;
          end
        end
      LPSC_DEEPEST, LPSC_PARTIAL:
        if (rst_pin == 1'b0 || ext_hit || one_hit
            || (s.level == LPSC_PARTIAL && periodic_on && s.tick))
        begin
          next_s.level          = LPSC_RESUME;
          next_s.resume_reset   = 1'b1;
          next_s.resume_partial = (s.level == LPSC_PARTIAL);
        end
      LPSC_HALTED:
        if (s.debug_mode_enable && debug_cmd)
        begin
          next_s.level             = LPSC_RESUME;
          next_s.evt.debug_entered = 1'b1;
        end
        else if (rst_pin == 1'b0)
        begin
          next_s.level        = LPSC_RESUME;
          next_s.resume_reset = 1'b1;
        end
        else if (ext_hit || one_hit || two_hit || (periodic_on && s.tick))
        begin
          next_s.level = LPSC_RESUME;
          next_s.evt.ext_vector       = ext_hit;
          next_s.evt.group_one_vector = !ext_hit && one_hit;
          next_s.evt.group_two_vector = !ext_hit && !one_hit && two_hit;
          next_s.evt.periodic_vector  = !ext_hit && !one_hit && !two_hit;
        end
      LPSC_RESUME:
      begin
        next_s.level = LPSC_RUN;
        if (s.resume_reset)
        begin
          next_s.evt.reset_vector = 1'b1;
          next_s.power_down_select         = 1'b0;
          next_s.partial_power_down_select = 1'b0;
          next_s.low_voltage_reset_enable  = 1'b0;
          next_s.periodic_rate_select      = RATE_OFF;
          next_s.stop_enable_bit           = 1'b0;
          next_s.debug_mode_enable         = 1'b0;
          next_s.wake_enable               = '0;
          next_s.periph_reset  = 1'b1;
          next_s.forced        = 1'b0;
          next_s.recovery_flag = s.resume_partial
                                 || s.recovery_flag;
        end
        next_s.resume_reset   = 1'b0;
        next_s.resume_partial = 1'b0;
        next_s.mem_kept       = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s          <= '0;
      s.level    <= LPSC_RUN;
      s.mem_kept <= 1'b1;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all decoded from state flops alone, the clock and regulator enables through gating
  always_comb
  begin
    rdata               = s.rdata;
    debug_answer        = s.dbg_ans;
    wake_event          = s.evt;
    pins_latched        = s.latched;
    pins_forced_reset   = s.forced;
    core_clock_enable   = (s.level == LPSC_RUN) || (s.level == LPSC_RESUME);
    periph_clock_enable = core_clock_enable;
    comparator_enable   = core_clock_enable;
    debug_clock_enable  = core_clock_enable || s.debug_mode_enable;
    regulator_full      = core_clock_enable || s.debug_mode_enable
                          || s.low_voltage_reset_enable;
    oscillator_enable   = core_clock_enable || s.debug_mode_enable;
    periph_reset        = s.periph_reset;
    memory_retained     = s.mem_kept;
    level               = s.level;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_illegal_stop: assert property (@(posedge clock) disable iff (rst)
    (level == LPSC_RUN && stop_exec && !s.stop_enable_bit)
    |=> wake_event.illegal_reset && level == LPSC_RUN)
    else $error("stop without enable did not force reset");
  chk_partial_entry: assert property (@(posedge clock) disable iff (rst)
    (level == LPSC_RUN && stop_exec && s.stop_enable_bit
     && s.power_down_select && s.partial_power_down_select
     && !s.low_voltage_reset_enable && !s.debug_mode_enable)
    |=> level == LPSC_PARTIAL && pins_latched)
    else $error("partial level not entered");
  chk_deep_blocked: assert property (@(posedge clock) disable iff (rst)
    (level == LPSC_RUN && stop_exec && s.stop_enable_bit
     && (s.debug_mode_enable || s.low_voltage_reset_enable))
    |=> level == LPSC_HALTED)
    else $error("deep request not turned into halted");
  chk_periph_gated: assert property (@(posedge clock) disable iff (rst)
    (level != LPSC_RUN && level != LPSC_RESUME) |-> !periph_clock_enable)
    else $error("peripheral clock running in stop");
  chk_flag_release: assert property (@(posedge clock) disable iff (rst)
    (bus.write && bus.addr == ADDR_CONTROL_TWO
     && bus.wdata[C2_PIN_RELEASE_ACK] && level == LPSC_RUN)
    |=> !pins_latched && !s.recovery_flag)
    else $error("acknowledge did not release latches");
  chk_partial_flag: assert property (@(posedge clock) disable iff (rst)
    (level == LPSC_RESUME && s.resume_partial)
    |=> s.recovery_flag && wake_event.reset_vector && pins_latched)
    else $error("partial wake missed flag or reset vector");
  chk_stop_answer: assert property (@(posedge clock) disable iff (rst)
    (debug_status_cmd && level == LPSC_HALTED)
    |=> debug_answer == DBG_ANS_STOPPED)
    else $error("status command not refused in stop");
  chk_debug_clock: assert property (@(posedge clock) disable iff (rst)
    (level == LPSC_HALTED && s.debug_mode_enable)
    |-> debug_clock_enable && regulator_full)
    else $error("debug clock stopped in stop");
  chk_no_two_deep: assert property (@(posedge clock) disable iff (rst)
    (level == LPSC_PARTIAL && two_hit && !ext_hit && !one_hit
     && rst_pin && !s.tick) |=> level == LPSC_PARTIAL)
    else $error("group two woke partial level");

  cov_partial: cover property (@(posedge clock) disable iff (rst)
    level == LPSC_PARTIAL ##[1:50] level == LPSC_RESUME);
  cov_deepest: cover property (@(posedge clock) disable iff (rst)
    level == LPSC_DEEPEST);
  cov_halted_int: cover property (@(posedge clock) disable iff (rst)
    wake_event.ext_vector);
endmodule
`default_nettype wire

/* File: pkg/lpsc_pkg.sv */
// constants, types and register map of the stop-mode controller
package lpsc_pkg;

  // register indices (byte address = index)
  localparam logic [3:0] ADDR_CONTROL_ONE = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_TWO = 4'h1;
  localparam logic [3:0] ADDR_OPTIONS     = 4'h2;
  localparam logic [3:0] ADDR_DEBUG       = 4'h3;
  localparam logic [3:0] ADDR_STATUS      = 4'h4;
  localparam logic [3:0] ADDR_WAKE_ENABLE = 4'h5;

  // power_mode_control_two fields
  localparam int C2_POWER_DOWN_SELECT = 0;
  localparam int C2_PARTIAL_SELECT    = 1;
  localparam int C2_PIN_RELEASE_ACK   = 2;
  localparam int C2_RECOVERY_FLAG     = 3;
  // power_mode_control_one fields
  localparam int C1_LOW_VOLTAGE_RESET = 0;
  // options fields
  localparam int OPT_STOP_ENABLE      = 0;
  localparam int OPT_RATE_LSB         = 1;
  // debug_control_status fields
  localparam int DBG_MODE_ENABLE      = 0;
  // wake enable fields
  localparam int WE_EXT_PIN           = 0;
  localparam int WE_GROUP_ONE         = 1;
  localparam int WE_GROUP_TWO         = 2;
  localparam int WE_EXT_ACTIVE_HIGH   = 3;
  localparam int WE_KEY_ACTIVE_HIGH   = 4;

  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic [2:0] RATE_OFF     = 3'h0;

  // one-kilohertz periodic tick: period in us, cycles at 50 MHz
  localparam int CLOCK_MHZ          = 50;
  localparam int PERIODIC_US        = 1000;
  localparam int PERIODIC_CYCLES    = PERIODIC_US * CLOCK_MHZ;

  // debug status answer codes
  localparam logic [1:0] DBG_ANS_OK      = 2'h1;
  localparam logic [1:0] DBG_ANS_STOPPED = 2'h2;

  typedef enum logic [4:0] {
    LPSC_RUN      = 5'b00001,
    LPSC_DEEPEST  = 5'b00010,
    LPSC_PARTIAL  = 5'b00100,
    LPSC_HALTED   = 5'b01000,
    LPSC_RESUME   = 5'b10000
  } lpsc_state_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [3:0] addr;
    logic [7:0] wdata;
  } lpsc_bus_t;

  typedef struct packed {
    logic reset_pin;
    logic ext_pin;
    logic [7:0] group_one;
    logic [7:0] group_two;
  } lpsc_wake_t;

  typedef struct packed {
    logic reset_vector;
    logic ext_vector;
    logic group_one_vector;
    logic group_two_vector;
    logic periodic_vector;
    logic illegal_reset;
    logic debug_entered;
  } lpsc_event_t;

endpackage

/* File: src/lpsc_sync.sv */
// two-flop synchroniser for asynchronous wake inputs
`timescale 1ns/1ns
`default_nettype none
module lpsc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } lpsc_sync_state_t;

  lpsc_sync_state_t state;
  lpsc_sync_state_t next_state;

  always_comb
  begin
    next_state.first  = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.second;
endmodule
`default_nettype wire

/* File: sim/tb_low_power_stop_mode_controller.sv */
// self-checking bench for the stop-mode controller
`timescale 1ns/1ns
`default_nettype none
module tb_low_power_stop_mode_controller;
  import lpsc_pkg::*;
  logic                  clock;
  logic                  rst;
  lpsc_bus_t             bus;
  logic [7:0]            rdata;
  logic                  stop_exec;
  lpsc_wake_t            wake_in;
  logic                  debug_cmd;
  logic                  debug_status_cmd;
  logic [1:0]            debug_answer;
  lpsc_event_t           wake_event;
  logic                  pins_latched;
  logic                  pins_forced_reset;
  logic                  core_clock_enable;
  logic                  periph_clock_enable;
  logic                  debug_clock_enable;
  logic                  oscillator_enable;
  logic                  regulator_full;
  logic                  comparator_enable;
  logic                  periph_reset;
  logic                  memory_retained;
  lpsc_state_t           level;
  int                    n_fail;
  int                    samples_checked;
  logic [7:0]            rd_val;

  lpsc_controller lpsc_controller_inst (
    .clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
    .stop_exec(stop_exec), .wake_in(wake_in), .debug_cmd(debug_cmd),
    .debug_status_cmd(debug_status_cmd), .debug_answer(debug_answer),
    .wake_event(wake_event), .pins_latched(pins_latched),
    .pins_forced_reset(pins_forced_reset),
    .core_clock_enable(core_clock_enable),
    .periph_clock_enable(periph_clock_enable),
    .debug_clock_enable(debug_clock_enable),
    .oscillator_enable(oscillator_enable),
    .regulator_full(regulator_full),
    .comparator_enable(comparator_enable),
    .periph_reset(periph_reset), .memory_retained(memory_retained),
    .level(level)
  );

  always #10 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    bus <= '0;
    #1;
    d = rdata;
  endtask

  // stop_exec, debug_cmd, debug_status_cmd as one-cycle pulses
  task automatic pulse(input logic [2:0] p);
    @(posedge clock);
    {stop_exec, debug_cmd, debug_status_cmd} <= p;
    @(posedge clock);
    {stop_exec, debug_cmd, debug_status_cmd} <= 3'b000;
    #1;
  endtask

  // bounded wait for any event bit in the mask
  task automatic wait_ev(input logic [6:0] mask);
    int i;
    for (i = 0; i < 40; i++)
    begin
      if ((wake_event & mask) !== 7'h00)
        break;
      @(posedge clock);
      #1;
    end
    chk(8'((wake_event & mask) !== 7'h00), 8'h01);
  endtask

  task automatic cfg(input logic [7:0] opt, input logic [7:0] c1,
                     input logic [7:0] c2, input logic [7:0] dbg,
                     input logic [7:0] we);
    wr(ADDR_OPTIONS, opt);
    wr(ADDR_CONTROL_ONE, c1);
    wr(ADDR_CONTROL_TWO, c2);
    wr(ADDR_DEBUG, dbg);
    wr(ADDR_WAKE_ENABLE, we);
  endtask

  task automatic idle_pins();
    @(posedge clock);
    wake_in <= '{reset_pin: 1'b1, ext_pin: 1'b1,
                 group_one: 8'hff, group_two: 8'hff};
    repeat (6) @(posedge clock);
  endtask

  task automatic done(input string name);
    $display("test %0s finished", name);
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (80000) @(posedge clock);
    n_fail++;
    results();
  end

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    bus = '0;
    stop_exec = 1'b0;
    debug_cmd = 1'b0;
    debug_status_cmd = 1'b0;
    wake_in = '{reset_pin: 1'b1, ext_pin: 1'b1,
                group_one: 8'hff, group_two: 8'hff};
    n_fail = 0;
    samples_checked = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    // reset state and unmapped read
    #1;
    chk(8'(level), 8'(LPSC_RUN));
    chk({memory_retained, periph_clock_enable, oscillator_enable,
         core_clock_enable}, 8'h0f);
    rd(ADDR_CONTROL_TWO, rd_val);
    chk(rd_val, RESET_BYTE);
    rd(4'hf, rd_val);
    chk(rd_val, 8'h00);
    done("reset");
    // stop with stop enable clear
    cfg(8'h00, 8'h00, 8'h03, 8'h00, 8'h00);
    pulse(3'b100);
    wait_ev(7'h02);
    chk(8'(level), 8'(LPSC_RUN));
    done("illegal");
    // partial level, ext configured high but wakes low
    cfg(8'h01, 8'h00, 8'h03, 8'h00, 8'h0d);
    pulse(3'b100);
    chk(8'(level), 8'(LPSC_PARTIAL));
    chk(8'(pins_latched), 8'h01);
    chk({periph_clock_enable, comparator_enable}, 8'h00);
    wake_in.group_two <= 8'hfe;
    repeat (12) @(posedge clock);
    #1;
    chk(8'(level), 8'(LPSC_PARTIAL));
    wake_in.group_two <= 8'hff;
    wake_in.ext_pin <= 1'b0;
    wait_ev(7'h40);
    idle_pins();
    chk({pins_latched, memory_retained}, 8'h03);
    rd(ADDR_CONTROL_TWO, rd_val);
    chk(rd_val, 8'h08);
    wr(ADDR_CONTROL_TWO, 8'h04);
    rd(ADDR_CONTROL_TWO, rd_val);
    chk(rd_val, 8'h00);
    chk(8'(pins_latched), 8'h00);
    done("partial");
    // deepest level, group one wake
    cfg(8'h01, 8'h00, 8'h01, 8'h00, 8'h02);
    pulse(3'b100);
    chk(8'(level), 8'(LPSC_DEEPEST));
    chk({pins_forced_reset, memory_retained}, 8'h02);
    wake_in.group_one <= 8'hfb;
    wait_ev(7'h40);
    idle_pins();
    rd(ADDR_OPTIONS, rd_val);
    chk(rd_val, RESET_BYTE);
    rd(ADDR_CONTROL_TWO, rd_val);
    chk(rd_val, 8'h00);
    chk(8'(memory_retained), 8'h01);
    done("deepest");
    // halted level, partial select ignored
    cfg(8'h01, 8'h00, 8'h02, 8'h00, 8'h04);
    pulse(3'b100);
    chk(8'(level), 8'(LPSC_HALTED));
    chk({core_clock_enable, oscillator_enable, periph_clock_enable,
         pins_latched}, 8'h00);
    pulse(3'b001);
    chk(8'(debug_answer), 8'(DBG_ANS_STOPPED));
    wake_in.group_two <= 8'hef;
    wait_ev(7'h08);
    idle_pins();
    rd(ADDR_OPTIONS, rd_val);
    chk(rd_val, 8'h01);
    done("halted");
    // low-voltage reset forces halted, reset pin exit
    cfg(8'h01, 8'h01, 8'h03, 8'h00, 8'h01);
    pulse(3'b100);
    chk(8'(level), 8'(LPSC_HALTED));
    chk(8'(regulator_full), 8'h01);
    wake_in.reset_pin <= 1'b0;
    wait_ev(7'h40);
    idle_pins();
    done("lowvolt");
    // debug enable forces halted, debug command wakes
    cfg(8'h01, 8'h00, 8'h01, 8'h01, 8'h00);
    pulse(3'b100);
    chk(8'(level), 8'(LPSC_HALTED));
    chk({debug_clock_enable, oscillator_enable, regulator_full,
         periph_clock_enable}, 8'h0e);
    pulse(3'b010);
    wait_ev(7'h01);
    repeat (4) @(posedge clock);
    pulse(3'b001);
    chk(8'(debug_answer), 8'(DBG_ANS_OK));
    done("debug");
    // rate select zero: no periodic wake
    cfg(8'h01, 8'h00, 8'h00, 8'h00, 8'h01);
    pulse(3'b100);
    repeat (PERIODIC_CYCLES + 200) @(posedge clock);
    #1;
    chk(8'(level), 8'(LPSC_HALTED));
    wake_in.ext_pin <= 1'b0;
    wait_ev(7'h20);
    idle_pins();
    done("rate_off");
    results();
  end
endmodule
`default_nettype wire
